// ### logic/hub_pins.sv
// Connect, port power, strap and reference clock pin control
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module hub_pins (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        upstream_power_detect,
  output logic             upstream_dplus_pullup_en,
  input  wire logic        crossover_default_strap,
  output logic             crossover_enable,
  input  wire logic        refclk_out_enable,
  output logic             refclk_out,
  input  wire logic        port_a_power_ctl_in,
  output logic             port_a_power_ctl_out,
  output logic             port_a_power_ctl_oe,
  input  wire logic        port_b_power_ctl_in,
  output logic             port_b_power_ctl_out,
  output logic             port_b_power_ctl_oe,
  output logic             port_a_overcurrent,
  output logic             port_b_overcurrent,
  input  wire logic        crystal_in,
  output logic             crystal_out,
  input  wire logic        external_reset_low
);
  sync_if sif ();

  pin_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sif     (sif.syncer)
  );

  // Every outside level passes two flops first
  assign sif.raw = {crystal_in, external_reset_low, refclk_out_enable,
                    crossover_default_strap, port_b_power_ctl_in,
                    port_a_power_ctl_in, upstream_power_detect};

  logic                                vbus_s;
  logic [hub_pins_pkg::NPORTS-1:0]     port_pin_s;
  logic                                strap_s;
  logic                                clken_s;
  logic                                ext_rst_s;
  logic                                xtal_s;
  assign vbus_s     = sif.sync[hub_pins_pkg::IDX_VBUS];
  assign port_pin_s = sif.sync[hub_pins_pkg::IDX_PORT0 +: hub_pins_pkg::NPORTS];
  assign strap_s    = sif.sync[hub_pins_pkg::IDX_STRAP];
  assign clken_s    = sif.sync[hub_pins_pkg::IDX_CLKEN];
  assign ext_rst_s  = sif.sync[hub_pins_pkg::IDX_RST];
  assign xtal_s     = sif.sync[hub_pins_pkg::IDX_XTAL];

  logic [hub_pins_pkg::CTRL_W-1:0] ctrl_r,      ctrl_nxt;
  logic [hub_pins_pkg::NPORTS-1:0] oc_r,        oc_nxt;
  logic                            strap_done_r, strap_done_nxt;
  logic                            wr_pend_r,   wr_pend_nxt;
  logic                            rd_pend_r,   rd_pend_nxt;
  logic [11:0]                     addr_r,      addr_nxt;
  logic                            hreadyout_r, hreadyout_nxt;
  logic [31:0]                     hrdata_r,    hrdata_nxt;
  logic                            pullup_r,    pullup_nxt;
  logic [7:0]                      acc_r,       acc_nxt;
  logic                            refclk_r,    refclk_nxt;
  logic                            xtal_d_r,    xtal_d_nxt;
  logic [3:0]                      xtal_gap_r,  xtal_gap_nxt;
  logic                            alive_r,     alive_nxt;
  logic                            xout_r,      xout_nxt;
  logic [hub_pins_pkg::NPORTS-1:0] pin_oe_r,    pin_oe_nxt;
  logic [hub_pins_pkg::NPORTS-1:0] oc_out_r,    oc_out_nxt;

  logic [hub_pins_pkg::NPORTS-1:0] power_on;
  logic [hub_pins_pkg::NPORTS-1:0] sense_mode;
  logic [hub_pins_pkg::NPORTS-1:0] oc_event;
  logic [31:0]                     status_word;
  logic [8:0]                      acc_sum;
  assign power_on   = ctrl_r[hub_pins_pkg::CTRL_POWER_ON +: hub_pins_pkg::NPORTS];
  assign sense_mode = ctrl_r[hub_pins_pkg::CTRL_SENSE_MODE +: hub_pins_pkg::NPORTS];

  // Per-port pin handling
  genvar p;
  generate
    for (p = 0; p < hub_pins_pkg::NPORTS; p++) begin : g_port
      // Input mode samples the monitor; low is overcurrent
      assign oc_event[p]   = sense_mode[p] & ~port_pin_s[p];
      // Output mode: release for power on, pull low for power off
      assign pin_oe_nxt[p] = ~sense_mode[p] & ~power_on[p];
    end
  endgenerate

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[hub_pins_pkg::STAT_UP_POWER]  = vbus_s;
    status_word[hub_pins_pkg::STAT_OVERCURRENT +: hub_pins_pkg::NPORTS] = oc_r;
    status_word[hub_pins_pkg::STAT_CLKEN]     = clken_s;
    status_word[hub_pins_pkg::STAT_STRAP]     = strap_s;
    status_word[hub_pins_pkg::STAT_REF_ALIVE] = alive_r;
  end

  assign acc_sum = {1'b0, acc_r} + {1'b0, hub_pins_pkg::ACC_STEP};

  always_comb begin
    ctrl_nxt       = ctrl_r;
    oc_nxt         = oc_r;
    strap_done_nxt = strap_done_r;
    wr_pend_nxt    = 1'b0;
    rd_pend_nxt    = 1'b0;
    addr_nxt       = addr_r;
    hreadyout_nxt  = 1'b1;
    hrdata_nxt     = hrdata_r;
    // Bus write lands at the end of its data phase
    if (wr_pend_r) begin
      if (addr_r == hub_pins_pkg::ADDR_CTRL) begin
        ctrl_nxt = hwdata[hub_pins_pkg::CTRL_W-1:0];
      end else if (addr_r == hub_pins_pkg::ADDR_STATUS) begin
        oc_nxt = oc_r & ~hwdata[hub_pins_pkg::STAT_OVERCURRENT +: hub_pins_pkg::NPORTS];
      end
    end
    // Read data formed one cycle after the address phase
    if (rd_pend_r) begin
      if (addr_r == hub_pins_pkg::ADDR_CTRL) begin
        hrdata_nxt = {{(32 - hub_pins_pkg::CTRL_W){1'b0}}, ctrl_r};
      end else if (addr_r == hub_pins_pkg::ADDR_STATUS) begin
        hrdata_nxt = status_word;
      end else begin
        hrdata_nxt = 32'h0000_0000;
      end
    end
    if (hsel && hready && htrans[1]) begin
      addr_nxt      = haddr[11:0];
      wr_pend_nxt   = hwrite;
      rd_pend_nxt   = ~hwrite;
      hreadyout_nxt = hwrite;
    end
    // Sticky overcurrent: a new event wins over a clear
    oc_nxt = oc_nxt | oc_event;
    // Strap taken once after reset release
    if (!strap_done_r) begin
      ctrl_nxt[hub_pins_pkg::CTRL_CROSSOVER] = strap_s;
      strap_done_nxt = 1'b1;
    end
    pullup_nxt = vbus_s & ctrl_nxt[hub_pins_pkg::CTRL_CONNECT_OK];
    // Fractional accumulator averages 24 MHz from the core clock
    acc_nxt    = acc_r;
    refclk_nxt = 1'b0;
    if (clken_s) begin
      refclk_nxt = refclk_r;
      if (acc_sum >= {1'b0, hub_pins_pkg::ACC_MOD}) begin
        acc_nxt    = 8'(acc_sum - {1'b0, hub_pins_pkg::ACC_MOD});
        refclk_nxt = ~refclk_r;
      end else begin
        acc_nxt = acc_sum[7:0];
      end
    end else begin
      acc_nxt = 8'h00;
    end
    // Reference activity watch on the 25 MHz input
    xtal_d_nxt   = xtal_s;
    xout_nxt     = ~xtal_s;
    xtal_gap_nxt = xtal_gap_r;
    if (xtal_s && !xtal_d_r) begin
      xtal_gap_nxt = 4'h0;
    end else if (xtal_gap_r != hub_pins_pkg::XTAL_DEAD_CYC) begin
      xtal_gap_nxt = xtal_gap_r + 4'h1;
    end
    alive_nxt  = (xtal_gap_nxt != hub_pins_pkg::XTAL_DEAD_CYC);
    oc_out_nxt = oc_nxt;
    // External reset pin returns all control state to reset
    if (!ext_rst_s) begin
      ctrl_nxt       = hub_pins_pkg::CTRL_RESET[hub_pins_pkg::CTRL_W-1:0];
      oc_nxt         = '0;
      oc_out_nxt     = '0;
      strap_done_nxt = 1'b0;
      pullup_nxt     = 1'b0;
      acc_nxt        = 8'h00;
      refclk_nxt     = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r       <= hub_pins_pkg::CTRL_RESET[hub_pins_pkg::CTRL_W-1:0];
      oc_r         <= '0;
      strap_done_r <= 1'b0;
      wr_pend_r    <= 1'b0;
      rd_pend_r    <= 1'b0;
      addr_r       <= 12'h000;
      hreadyout_r  <= 1'b1;
      hrdata_r     <= 32'h0000_0000;
      pullup_r     <= 1'b0;
      acc_r        <= 8'h00;
      refclk_r     <= 1'b0;
      xtal_d_r     <= 1'b0;
      xtal_gap_r   <= hub_pins_pkg::XTAL_DEAD_CYC;
      alive_r      <= 1'b0;
      xout_r       <= 1'b0;
      pin_oe_r     <= '0;
      oc_out_r     <= '0;
    end else begin
      ctrl_r       <= ctrl_nxt;
      oc_r         <= oc_nxt;
      strap_done_r <= strap_done_nxt;
      wr_pend_r    <= wr_pend_nxt;
      rd_pend_r    <= rd_pend_nxt;
      addr_r       <= addr_nxt;
      hreadyout_r  <= hreadyout_nxt;
      hrdata_r     <= hrdata_nxt;
      pullup_r     <= pullup_nxt;
      acc_r        <= acc_nxt;
      refclk_r     <= refclk_nxt;
      xtal_d_r     <= xtal_d_nxt;
      xtal_gap_r   <= xtal_gap_nxt;
      alive_r      <= alive_nxt;
      xout_r       <= xout_nxt;
      pin_oe_r     <= pin_oe_nxt;
      oc_out_r     <= oc_out_nxt;
    end
  end

  // Open-drain data is a constant low flop; only the enable moves
  logic zero_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_r <= 1'b0;
    end else begin
      zero_r <= 1'b0;
    end
  end

  assign hreadyout                = hreadyout_r;
  assign hrdata                   = hrdata_r;
  assign hresp                    = zero_r;
  assign upstream_dplus_pullup_en = pullup_r;
  assign crossover_enable         = ctrl_r[hub_pins_pkg::CTRL_CROSSOVER];
  assign refclk_out               = refclk_r;
  assign port_a_power_ctl_out     = zero_r;
  assign port_b_power_ctl_out     = zero_r;
  assign port_a_power_ctl_oe      = pin_oe_r[0];
  assign port_b_power_ctl_oe      = pin_oe_r[1];
  assign port_a_overcurrent       = oc_out_r[0];
  assign port_b_overcurrent       = oc_out_r[1];
  assign crystal_out              = xout_r;
endmodule // hub_pins

// ### logic/hub_pins_pkg.sv
// Constants for the hub pin control block
package hub_pins_pkg;
  localparam int unsigned SYNC_W           = 7;
  localparam int unsigned IDX_VBUS         = 0;
  localparam int unsigned IDX_PORT0        = 1;
  localparam int unsigned IDX_STRAP        = 3;
  localparam int unsigned IDX_CLKEN        = 4;
  localparam int unsigned IDX_RST          = 5;
  localparam int unsigned IDX_XTAL         = 6;
  localparam int unsigned NPORTS           = 2;

  localparam logic [11:0] ADDR_CTRL        = 12'h000;
  localparam logic [11:0] ADDR_STATUS      = 12'h004;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0010;
  localparam int unsigned CTRL_POWER_ON    = 0;
  localparam int unsigned CTRL_SENSE_MODE  = 2;
  localparam int unsigned CTRL_CONNECT_OK  = 4;
  localparam int unsigned CTRL_CROSSOVER   = 5;
  localparam int unsigned CTRL_W           = 6;
  localparam int unsigned STAT_UP_POWER    = 0;
  localparam int unsigned STAT_OVERCURRENT = 1;
  localparam int unsigned STAT_CLKEN       = 3;
  localparam int unsigned STAT_STRAP       = 4;
  localparam int unsigned STAT_REF_ALIVE   = 5;

  localparam int unsigned HCLK_MHZ         = 100;
  localparam int unsigned REFOUT_MHZ       = 24;
  localparam int unsigned XTAL_MHZ         = 25;
  localparam logic [7:0]  ACC_MOD          = 8'(HCLK_MHZ);
  localparam logic [7:0]  ACC_STEP         = 8'(2 * REFOUT_MHZ);
  localparam int unsigned XTAL_PERIOD_CYC  = HCLK_MHZ / XTAL_MHZ;
  localparam logic [3:0]  XTAL_DEAD_CYC    = 4'(2 * XTAL_PERIOD_CYC);
endpackage

// ### logic/sync_if.sv
// Raw pin levels and their synchronised copies
`timescale 1ns/10ps
interface sync_if;
  logic [hub_pins_pkg::SYNC_W-1:0] raw;
  logic [hub_pins_pkg::SYNC_W-1:0] sync;
  modport user    (output raw, input sync);
  modport syncer  (input raw, output sync);
endinterface

// ### logic/pin_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module pin_sync (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  sync_if.syncer      sif
);
  logic [hub_pins_pkg::SYNC_W-1:0] meta_r;
  logic [hub_pins_pkg::SYNC_W-1:0] sync_r;

  genvar i;
  generate
    for (i = 0; i < hub_pins_pkg::SYNC_W; i++) begin : g_bit
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= sif.raw[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign sif.sync = sync_r;
endmodule // pin_sync

// ### testbench/hub_pins_asserts.sv
// Port-level checks for the hub pin control block
`timescale 1ns/10ps
module hub_pins_asserts (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       upstream_power_detect,
  input wire logic       upstream_dplus_pullup_en,
  input wire logic       refclk_out_enable,
  input wire logic       refclk_out,
  input wire logic       port_a_power_ctl_in,
  input wire logic       port_a_power_ctl_out,
  input wire logic       port_b_power_ctl_out,
  input wire logic       port_a_overcurrent,
  input wire logic       crystal_in,
  input wire logic       crystal_out,
  input wire logic       external_reset_low
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_vbus_new;
    !upstream_power_detect [*2] ##1 upstream_power_detect;
  endsequence
  sequence s_rd_req;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_pullup;
    upstream_dplus_pullup_en |-> $past(upstream_power_detect, 3);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup without power");
  property p_vbus_sync;
    s_vbus_new |=> !upstream_dplus_pullup_en [*2];
  endproperty
  a_vbus_sync: assert property (p_vbus_sync) else $error("power seen too soon");
  property p_refclk_off;
    !refclk_out_enable [*5] |-> !refclk_out;
  endproperty
  a_refclk_off: assert property (p_refclk_off) else $error("refclk while disabled");
  property p_refclk_pace;
    $changed(refclk_out) |=> $stable(refclk_out) || !$past(refclk_out_enable, 3) ||
      !$past(external_reset_low, 3);
  endproperty
  a_refclk_pace: assert property (p_refclk_pace) else $error("refclk too fast");
  property p_out_low;
    !port_a_power_ctl_out && !port_b_power_ctl_out;
  endproperty
  a_out_low: assert property (p_out_low) else $error("power pin driven high");
  property p_oc_cause;
    $rose(port_a_overcurrent) |->
      !$past(port_a_power_ctl_in, 3) || !$past(port_a_power_ctl_in, 4);
  endproperty
  a_oc_cause: assert property (p_oc_cause) else $error("overcurrent without low pin");
  property p_ext_reset;
    !external_reset_low [*4] |->
      !upstream_dplus_pullup_en && !refclk_out && !port_a_overcurrent;
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("state kept in reset");
  property p_xtal;
    $past(hresetn, 4) |-> crystal_out == !$past(crystal_in, 3);
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal output wrong");
  property p_read_wait;
    s_rd_req |=> s_one_wait;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait not one cycle");
endmodule // hub_pins_asserts

bind hub_pins hub_pins_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .upstream_power_detect(upstream_power_detect),
  .upstream_dplus_pullup_en(upstream_dplus_pullup_en),
  .refclk_out_enable(refclk_out_enable), .refclk_out(refclk_out),
  .port_a_power_ctl_in(port_a_power_ctl_in), .port_a_power_ctl_out(port_a_power_ctl_out),
  .port_b_power_ctl_out(port_b_power_ctl_out), .port_a_overcurrent(port_a_overcurrent),
  .crystal_in(crystal_in), .crystal_out(crystal_out),
  .external_reset_low(external_reset_low));

// ### testbench/port_power_partner.sv
// Open-drain power pins with current monitors, and reference oscillator
`timescale 1ns/10ps
module port_power_partner (
  input  wire logic oe_a,
  input  wire logic oe_b,
  input  wire logic fault_a,
  input  wire logic fault_b,
  input  wire logic osc_run,
  output logic      pin_a,
  output logic      pin_b,
  output logic      xtal
);
  // Pull-up wins unless device or monitor pulls low
  assign pin_a = !(oe_a || fault_a);
  assign pin_b = !(oe_b || fault_b);
  // 25 MHz oscillator, held low when stopped
  initial xtal = 1'b0;
  always #20 xtal = osc_run ? !xtal : 1'b0;
endmodule // port_power_partner

// ### testbench/tb_top.sv
// Self-checking bench for the hub pin control block
`timescale 1ns/10ps
module tb_top;
  logic        hclk, hresetn, hwrite, hrdy, hresp, vbus, strap, clken, ext_n, fa, fb, run;
  logic        pull, xen, rclk, pa, pb, pa_out, pa_oe, pb_out, pb_oe, oca, ocb, xin, xout;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  int          fails, n_checks, c;
  hub_pins uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .upstream_power_detect(vbus),
    .upstream_dplus_pullup_en(pull), .crossover_default_strap(strap),
    .crossover_enable(xen), .refclk_out_enable(clken), .refclk_out(rclk),
    .port_a_power_ctl_in(pa), .port_a_power_ctl_out(pa_out), .port_a_power_ctl_oe(pa_oe),
    .port_b_power_ctl_in(pb), .port_b_power_ctl_out(pb_out), .port_b_power_ctl_oe(pb_oe),
    .port_a_overcurrent(oca), .port_b_overcurrent(ocb), .crystal_in(xin),
    .crystal_out(xout), .external_reset_low(ext_n));
  port_power_partner u_far (.oe_a(pa_oe), .oe_b(pb_oe), .fault_a(fa), .fault_b(fb),
    .osc_run(run), .pin_a(pa), .pin_b(pb), .xtal(xin));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task report_and_stop;
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task w(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
    haddr <= {20'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (!hrdy) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hrdy) @(posedge hclk);
    r = hrdata;
  endtask
  task cnt;
    logic p;
    c = 0;
    p = rclk;
    repeat (100) begin
      @(posedge hclk);
      if (rclk && !p) c++;
      p = rclk;
    end
  endtask
  task t_reset;
    xfer(12'h000, 1'b0, 32'h0);
    chk("ctrl reset", r, 32'h0000_0030);
    chk("crossover", xen, 1'b1);
    chk("hresp okay", hresp, 1'b0);
    xfer(12'h008, 1'b1, 32'hFFFF_FFFF);
    xfer(12'h008, 1'b0, 32'h0);
    chk("unmapped", r, 32'h0);
  endtask
  task t_conn;
    chk("pullup idle", pull, 1'b0);
    vbus <= 1'b1;
    w(5);
    chk("pullup on", pull, 1'b1);
    xfer(12'h004, 1'b0, 32'h0);
    chk("power stat", r[0], 1'b1);
    vbus <= 1'b0;
    w(5);
    chk("pullup off", pull, 1'b0);
  endtask
  task t_power;
    chk("oe a off", pa_oe, 1'b1);
    xfer(12'h000, 1'b1, 32'h0000_0031);
    w(2);
    chk("oe a on", {pa_oe, pb_oe, pa, pb}, 4'h6);
    xfer(12'h000, 1'b1, 32'h0000_0032);
    w(2);
    chk("oe b on", {pa_oe, pb_oe, pa, pb}, 4'h9);
  endtask
  task t_oc;
    xfer(12'h000, 1'b1, 32'h0000_003C);
    fa <= 1'b1;
    fb <= 1'b1;
    w(6);
    chk("oc flags", {oca, ocb, pa_oe, pb_oe}, 4'hC);
    fa <= 1'b0;
    fb <= 1'b0;
    w(5);
    xfer(12'h004, 1'b0, 32'h0);
    chk("oc sticky", r[2:1], 2'h3);
    xfer(12'h004, 1'b1, 32'h0000_0002);
    w(2);
    chk("oc clear", {oca, ocb}, 2'h1);
    xfer(12'h004, 1'b1, 32'h0000_0004);
    w(2);
    chk("oc clear b", ocb, 1'b0);
  endtask
  task t_clk;
    cnt;
    chk("refclk off", c, 0);
    clken <= 1'b1;
    w(4);
    cnt;
    chk("refclk rate", (c >= 23 && c <= 25), 1);
    clken <= 1'b0;
    w(6);
    chk("refclk idle", rclk, 1'b0);
  endtask
  task t_xtal;
    xfer(12'h004, 1'b0, 32'h0);
    chk("ref alive", r[5], 1'b1);
    run <= 1'b0;
    w(12);
    xfer(12'h004, 1'b0, 32'h0);
    chk("ref dead", r[5], 1'b0);
    run <= 1'b1;
  endtask
  task t_ext;
    strap <= 1'b0;
    vbus <= 1'b1;
    xfer(12'h000, 1'b1, 32'h0000_003F);
    fa <= 1'b1;
    w(6);
    fa <= 1'b0;
    ext_n <= 1'b0;
    w(5);
    chk("ext reset", {pull, oca}, 2'h0);
    ext_n <= 1'b1;
    w(6);
    xfer(12'h000, 1'b0, 32'h0);
    chk("ctrl after ext", r, 32'h0000_0010);
    chk("crossover off", xen, 1'b0);
  endtask
  initial begin
    fails = 0;
    n_checks = 0;
    hresetn = 1'b0;
    {hwrite, vbus, clken, fa, fb} = 5'h0;
    {strap, ext_n, run} = 3'h7;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Strap lands only once the reset-pin synchroniser has filled
    w(3);
    t_reset;
    t_conn;
    t_power;
    t_oc;
    t_clk;
    t_xtal;
    t_ext;
    report_and_stop;
  end
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
endmodule // tb_top
